// file: rtcam_defines.svh
// register offsets, field positions and reset values of the alarm-match block
`ifndef RTCAM_DEFINES_SVH
`define RTCAM_DEFINES_SVH

// =============================================
// register byte offsets
`define RTCAM_OFF_DATE_SETUP 8'h10
`define RTCAM_OFF_TIME_SETUP 8'h14
`define RTCAM_OFF_CUR_DATE   8'h18
`define RTCAM_OFF_CUR_TIME   8'h1c
`define RTCAM_OFF_RAW_IRQ    8'h20
`define RTCAM_OFF_IRQ_ENABLE 8'h24
`define RTCAM_OFF_IRQ_FORCE  8'h28
`define RTCAM_OFF_IRQ_STATUS 8'h2c

// =============================================
// date setup word fields
`define RTCAM_ARMED_BIT      29
`define RTCAM_ARM_BIT        28
`define RTCAM_YEAR_ON_BIT    26
`define RTCAM_MONTH_ON_BIT   25
`define RTCAM_MDAY_ON_BIT    24
`define RTCAM_YEAR_HI        23
`define RTCAM_YEAR_LO        12
`define RTCAM_MONTH_HI       11
`define RTCAM_MONTH_LO       8
`define RTCAM_MDAY_HI        4
`define RTCAM_MDAY_LO        0

// =============================================
// time setup word fields
`define RTCAM_WDAY_ON_BIT    31
`define RTCAM_HOURS_ON_BIT   30
`define RTCAM_MINS_ON_BIT    29
`define RTCAM_SECS_ON_BIT    28
`define RTCAM_WDAY_HI        26
`define RTCAM_WDAY_LO        24
`define RTCAM_HOURS_HI       20
`define RTCAM_HOURS_LO       16
`define RTCAM_MINS_HI        13
`define RTCAM_MINS_LO        8
`define RTCAM_SECS_HI        5
`define RTCAM_SECS_LO        0

// =============================================
// reset values and bus answers
`define RTCAM_RST_WORD       32'h0000_0000
`define RTCAM_RESP_OKAY      2'h0
`define RTCAM_RESP_SLVERR    2'h2

`endif

// file: rtcam_pkg.sv
// types shared by the alarm-match block
package rtcam_pkg;

	// =============================================
	// calendar value as the counter core presents it
	typedef struct packed {
		logic [11:0] year;      // full year
		logic [3:0]  month;     // 1..12
		logic [4:0]  mday;      // 1..31
		logic [2:0]  weekday;   // 0 = sunday
		logic [4:0]  hours;     // 0..23
		logic [5:0]  minutes;   // 0..59
		logic [5:0]  seconds;   // 0..59
	} rtcam_cal_t;

	// =============================================
	// per-field compare enables
	typedef struct packed {
		logic year_compare_on;
		logic month_compare_on;
		logic mday_compare_on;
		logic weekday_compare_on;
		logic hours_compare_on;
		logic minutes_compare_on;
		logic seconds_compare_on;
	} rtcam_ena_t;

	// write channel state machine
	typedef enum logic [1:0] {
		RTCAM_W_IDLE = 2'b00,
		RTCAM_W_RESP = 2'b01
	} rtcam_wstate_t;

endpackage

// file: rtcam_match.sv
// field-by-field comparison of the running calendar against the alarm setup
`timescale 1ns/1ns
module rtcam_match
	import rtcam_pkg::*;
(
	input  wire logic              aclk,      // system clock
	input  wire logic              aresetn,   // synchronous reset, low active
	input  wire logic              arm,       // global alarm arm
	input  wire rtcam_pkg::rtcam_ena_t ena,   // per-field enables
	input  wire rtcam_pkg::rtcam_cal_t cmp,   // compare values
	input  wire rtcam_pkg::rtcam_cal_t now,   // live calendar
	output logic                   hit_q      // registered match level
);
	logic [6:0] eq;   // field equality
	logic [6:0] on;   // field enables

	// =============================================
	// field comparison
	assign eq = {now.year == cmp.year, now.month == cmp.month, now.mday == cmp.mday,
		now.weekday == cmp.weekday, now.hours == cmp.hours,
		now.minutes == cmp.minutes, now.seconds == cmp.seconds};
	assign on = ena;

	// a disabled field always agrees; no fields enabled matches every cycle while armed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= arm && ((eq | ~on) == 7'h7f);
		end
	end
endmodule

// file: rtcam_sync.sv
// three-stage synchroniser for a bus of slow-changing inputs
`timescale 1ns/1ns
module rtcam_sync #(
	parameter int W = 1   // bus width
) (
	input  wire logic         aclk,    // system clock
	input  wire logic         aresetn, // synchronous reset, low active
	input  wire logic [W-1:0] din,     // asynchronous input
	output logic      [W-1:0] dout_q   // filtered output
);
	logic [W-1:0] s1_q;  // first stage, read only by s2
	logic [W-1:0] s2_q;  // second stage
	logic [W-1:0] s3_q;  // third stage

	// =============================================
	// refuse a bus of no width at elaboration
	if (W < 1) begin : g_width_chk
		$error("width must be positive");
	end

	// =============================================
	// stages; a bit updates once the second and third agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			dout_q <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					dout_q[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

// file: rtcam_top.sv
// alarm-match and interrupt registers of the calendar clock, AXI4-Lite slave
// =============================================
`timescale 1ns/1ns
`include "rtcam_defines.svh"
module rtcam_top
	import rtcam_pkg::*;
(
	input  wire logic              aclk,          // system clock
	input  wire logic              aresetn,       // synchronous reset, low active
	input  wire logic [7:0]        s_axi_awaddr,  // write address
	input  wire logic              s_axi_awvalid, // write address valid
	output logic                   s_axi_awready, // write address ready
	input  wire logic [31:0]       s_axi_wdata,   // write data
	input  wire logic [3:0]        s_axi_wstrb,   // byte enables
	input  wire logic              s_axi_wvalid,  // write data valid
	output logic                   s_axi_wready,  // write data ready
	output logic [1:0]             s_axi_bresp,   // write response
	output logic                   s_axi_bvalid,  // write response valid
	input  wire logic              s_axi_bready,  // write response ready
	input  wire logic [7:0]        s_axi_araddr,  // read address
	input  wire logic              s_axi_arvalid, // read address valid
	output logic                   s_axi_arready, // read address ready
	output logic [31:0]            s_axi_rdata,   // read data
	output logic [1:0]             s_axi_rresp,   // read response
	output logic                   s_axi_rvalid,  // read data valid
	input  wire logic              s_axi_rready,  // read data ready
	input  wire rtcam_pkg::rtcam_cal_t cal_now,   // live calendar from the counter core
	output logic                   alarm_irq_q    // level interrupt
);
	// =============================================
	// register map, one aligned 32-bit word each
	// 0x10 date setup: arm, armed status, date enables and compare values
	// 0x14 time setup: time enables and compare values
	// 0x18 live date, read only
	// 0x1c live time, read only
	// 0x20 raw alarm flag, read only
	// 0x24 interrupt enable, bit 0
	// 0x28 interrupt force, bit 0
	// 0x2c interrupt level after enable and force, read only
	// anything else answers with a slave error and zero data
	// writes to read-only words are dropped but still answer okay
	// limitation: the raw flag follows the match level and drops when the
	// calendar moves on, so software polling slower than one step can miss it

	// =============================================
	// register storage
	logic [31:0]   date_setup_q;  // arm, enables, date compare
	logic [31:0]   time_setup_q;  // enables, time compare
	logic          raw_irq_q;     // raw alarm flag
	logic          irq_en_q;      // interrupt enable
	logic          irq_force_q;   // interrupt force
	logic          hit_q;         // match level from comparator
	rtcam_cal_t    cal_sync;      // synchronised calendar
	rtcam_cal_t    cmp;           // compare values
	rtcam_ena_t    ena;           // field enables

	// write channel
	rtcam_wstate_t wstate_q;      // write state
	logic          aw_have_q;     // address captured
	logic          w_have_q;      // data captured
	logic [7:0]    waddr_q;       // captured address
	logic [31:0]   wdata_q;       // captured data
	logic [3:0]    wstrb_q;       // captured strobes
	logic          wr_do;         // perform write this cycle

	// =============================================
	// byte-lane merge, used by the two setup words; enable and force take lane 0 directly
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction

	// =============================================
	// interrupt level, shared by the output flop and the status word
	function automatic logic irq_level(input logic raw, input logic en, input logic frc);
		return (raw & en) | frc;
	endfunction

	// =============================================
	// offsets that answer okay; the rest get a slave error
	function automatic logic addr_mapped(input logic [7:0] a);
		return a[7:2] >= 6'(`RTCAM_OFF_DATE_SETUP >> 2) &&
			a[7:2] <= 6'(`RTCAM_OFF_IRQ_STATUS >> 2);
	endfunction

	// =============================================
	// the live words pack the calendar into 41 bits; refuse a struct that drifts
	if ($bits(rtcam_cal_t) != 41) begin : g_cal_width_chk
		$error("calendar struct width does not match the live words");
	end

	// =============================================
	// calendar arrives from the slow clock, so pass it through a synchroniser;
	// a multi-bit roll may briefly mix fields, which is why software reads time first
	rtcam_sync #(.W($bits(rtcam_cal_t))) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (cal_now),
		.dout_q  (cal_sync)
	);

	// =============================================
	// field decode of the setup words
	// plain slices, so nothing sits between storage and the comparator
	assign ena.year_compare_on    = date_setup_q[`RTCAM_YEAR_ON_BIT];
	assign ena.month_compare_on   = date_setup_q[`RTCAM_MONTH_ON_BIT];
	assign ena.mday_compare_on    = date_setup_q[`RTCAM_MDAY_ON_BIT];
	assign ena.weekday_compare_on = time_setup_q[`RTCAM_WDAY_ON_BIT];
	assign ena.hours_compare_on   = time_setup_q[`RTCAM_HOURS_ON_BIT];
	assign ena.minutes_compare_on = time_setup_q[`RTCAM_MINS_ON_BIT];
	assign ena.seconds_compare_on = time_setup_q[`RTCAM_SECS_ON_BIT];
	assign cmp.year    = date_setup_q[`RTCAM_YEAR_HI:`RTCAM_YEAR_LO];
	assign cmp.month   = date_setup_q[`RTCAM_MONTH_HI:`RTCAM_MONTH_LO];
	assign cmp.mday    = date_setup_q[`RTCAM_MDAY_HI:`RTCAM_MDAY_LO];
	assign cmp.weekday = time_setup_q[`RTCAM_WDAY_HI:`RTCAM_WDAY_LO];
	assign cmp.hours   = time_setup_q[`RTCAM_HOURS_HI:`RTCAM_HOURS_LO];
	assign cmp.minutes = time_setup_q[`RTCAM_MINS_HI:`RTCAM_MINS_LO];
	assign cmp.seconds = time_setup_q[`RTCAM_SECS_HI:`RTCAM_SECS_LO];

	// =============================================
	// comparator; software keeps setup steady while armed, so no glitch guard here
	rtcam_match u_match (
		.aclk    (aclk),
		.aresetn (aresetn),
		.arm     (date_setup_q[`RTCAM_ARM_BIT]),
		.ena     (ena),
		.cmp     (cmp),
		.now     (cal_sync),
		.hit_q   (hit_q)
	);

	// =============================================
	// raw flag follows the match level; it drops when the calendar moves on
	// a level copy, so there is nothing for software to clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			raw_irq_q <= 1'b0;
		end else begin
			raw_irq_q <= hit_q;
		end
	end

	// =============================================
	// interrupt output, registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_irq_q <= 1'b0;
		end else begin
			alarm_irq_q <= irq_level(raw_irq_q, irq_en_q, irq_force_q);
		end
	end

	// =============================================
	// write channel: take address and data in either order, answer once both are in
	assign wr_do = (wstate_q == RTCAM_W_IDLE) && aw_have_q && w_have_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate_q      <= RTCAM_W_IDLE;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			waddr_q       <= 8'h00;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RTCAM_RESP_OKAY;
		end else begin
			case (wstate_q)
				RTCAM_W_IDLE: begin
					// ready pulses one cycle per captured item
					s_axi_awready <= !aw_have_q && s_axi_awvalid && !s_axi_awready;
					s_axi_wready  <= !w_have_q && s_axi_wvalid && !s_axi_wready;
					if (s_axi_awvalid && s_axi_awready) begin
						aw_have_q <= 1'b1;
						waddr_q   <= s_axi_awaddr;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_have_q <= 1'b1;
						wdata_q  <= s_axi_wdata;
						wstrb_q  <= s_axi_wstrb;
					end
					// both halves in hand: commit and answer
					if (wr_do) begin
						aw_have_q    <= 1'b0;
						w_have_q     <= 1'b0;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= addr_mapped(waddr_q) ?
							`RTCAM_RESP_OKAY : `RTCAM_RESP_SLVERR;
						wstate_q     <= RTCAM_W_RESP;
					end
				end
				// answer held until the master takes it
				RTCAM_W_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						wstate_q     <= RTCAM_W_IDLE;
					end
				end
				default: begin
					// stray code, fall back to idle
					wstate_q <= RTCAM_W_IDLE;
				end
			endcase
		end
	end

	// =============================================
	// writable registers; read-only words ignore writes but still answer okay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			date_setup_q <= `RTCAM_RST_WORD;
			time_setup_q <= `RTCAM_RST_WORD;
			irq_en_q     <= 1'b0;
			irq_force_q  <= 1'b0;
		end else if (wr_do) begin
			case ({waddr_q[7:2], 2'b00})
				`RTCAM_OFF_DATE_SETUP: begin
					// armed-status bit and reserved bits stay zero in storage
					date_setup_q <= merge(date_setup_q, wdata_q, wstrb_q) & 32'h17ff_ff1f;
				end
				`RTCAM_OFF_TIME_SETUP: begin
					time_setup_q <= merge(time_setup_q, wdata_q, wstrb_q) & 32'hf71f_3f3f;
				end
				// enable and force keep bit 0 only
				`RTCAM_OFF_IRQ_ENABLE: begin
					if (wstrb_q[0]) irq_en_q <= wdata_q[0];
				end
				`RTCAM_OFF_IRQ_FORCE: begin
					if (wstrb_q[0]) irq_force_q <= wdata_q[0];
				end
				default: begin
					// read-only and unmapped words: nothing stored
				end
			endcase
		end
	end

	// =============================================
	// read channel: one cycle to accept, next cycle data
	// a new address is held off while an answer is still out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RTCAM_RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RTCAM_RESP_OKAY;
				case ({s_axi_araddr[7:2], 2'b00})
					`RTCAM_OFF_DATE_SETUP: begin
						s_axi_rdata <= date_setup_q;
						s_axi_rdata[`RTCAM_ARMED_BIT] <= date_setup_q[`RTCAM_ARM_BIT];
					end
					`RTCAM_OFF_TIME_SETUP: s_axi_rdata <= time_setup_q;
					`RTCAM_OFF_CUR_DATE: begin
						s_axi_rdata <= {8'h00, cal_sync.year, cal_sync.month, 3'h0,
							cal_sync.mday};
					end
					`RTCAM_OFF_CUR_TIME: begin
						s_axi_rdata <= {5'h00, cal_sync.weekday, 3'h0, cal_sync.hours,
							2'h0, cal_sync.minutes, 2'h0, cal_sync.seconds};
					end
					`RTCAM_OFF_RAW_IRQ:    s_axi_rdata <= {31'h0, raw_irq_q};
					`RTCAM_OFF_IRQ_ENABLE: s_axi_rdata <= {31'h0, irq_en_q};
					`RTCAM_OFF_IRQ_FORCE:  s_axi_rdata <= {31'h0, irq_force_q};
					`RTCAM_OFF_IRQ_STATUS: begin
						s_axi_rdata <= {31'h0, irq_level(raw_irq_q, irq_en_q, irq_force_q)};
					end
					default: begin
						// reserved or unmapped offset
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `RTCAM_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// file: rtcam_assertions.sv
// port checker of the alarm-match register block
`timescale 1ns/1ns
module rtcam_checker (
	input wire logic        aclk,          // system clock
	input wire logic        aresetn,       // reset, low active
	input wire logic [7:0]  s_axi_araddr,  // read address
	input wire logic        s_axi_arvalid, // read address valid
	input wire logic        s_axi_arready, // read address taken
	input wire logic [31:0] s_axi_rdata,   // read data
	input wire logic [1:0]  s_axi_rresp,   // read answer code
	input wire logic        s_axi_rvalid,  // read answer valid
	input wire logic        alarm_irq_q    // level interrupt
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// =====
	// address of the read whose answer is out
	logic [7:0] ra_q;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ra_q <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			ra_q <= s_axi_araddr;
	end
	// =====
	// register map answers, looked at in the first answer cycle only
	chk_date_resv: assert property ($rose(s_axi_rvalid) && ra_q == 8'h10 |->
		(s_axi_rdata & 32'hc800_00e0) == 32'h0) else $error("date setup reserved bits set");
	chk_time_resv: assert property ($rose(s_axi_rvalid) && ra_q == 8'h14 |->
		(s_axi_rdata & 32'h08e0_c0c0) == 32'h0) else $error("time setup reserved bits set");
	chk_armed_copy: assert property ($rose(s_axi_rvalid) && ra_q == 8'h10 |->
		s_axi_rdata[29] == s_axi_rdata[28]) else $error("armed status differs from arm");
	chk_live_resv: assert property ($rose(s_axi_rvalid) && ra_q[7:3] == 5'h03 |->
		(s_axi_rdata & (ra_q[2] ? 32'hf8e0_c0c0 : 32'hff00_00e0)) == 32'h0)
		else $error("live calendar reserved bits set");
	chk_irq_resv: assert property ($rose(s_axi_rvalid) && ra_q[7:4] == 4'h2 |->
		s_axi_rdata[31:1] == 31'h0) else $error("interrupt word upper bits set");
	chk_map_resp: assert property ($rose(s_axi_rvalid) |->
		(ra_q[7:2] < 6'h04 || ra_q[7:2] > 6'h0b) ? (s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		: s_axi_rresp == 2'h0) else $error("read answer code wrong for address");
	// a calm pin must agree with the status word read back
	chk_irq_status: assert property ($rose(s_axi_rvalid) && ra_q == 8'h2c
		&& $stable(alarm_irq_q) && $past(alarm_irq_q, 3) == alarm_irq_q
		|-> s_axi_rdata[0] == alarm_irq_q) else $error("status word and pin differ");
	chk_irq_reset: assert property ($rose(aresetn) |-> !alarm_irq_q [*2])
		else $error("interrupt high after reset");
	// =====
	// main scenarios seen
	cover property ($rose(alarm_irq_q));
	cover property ($rose(s_axi_rvalid) && ra_q == 8'h20 && s_axi_rdata[0]);
	cover property ($rose(s_axi_rvalid) && s_axi_rresp == 2'h2);
endmodule

bind rtcam_top rtcam_checker chk_u (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.alarm_irq_q(alarm_irq_q)
);

// file: test_rtc_alarm_match_irq.sv
// self-checking bench of the alarm-match register block
`timescale 1ns/1ns
module test_rtc_alarm_match_irq;
	import rtcam_pkg::*;
	// =====
	// expected bus answer, noted by the driver
	typedef struct {logic [31:0] data; logic [1:0] resp;} rtcam_note_t;
	rtcam_note_t rq[$], bq[$], n;
	logic       aclk = 1'h0, aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [3:0] wstrb = 4'hf;    // byte lanes of the next write
	logic       awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0, rdata, d, dlast = 32'h0;
	logic [1:0] bresp, rresp;
	logic       awready, wready, bvalid, arready, rvalid, irq;
	logic [40:0] one = 41'h1;    // single flipped bit of a field
	rtcam_cal_t cal, cmp;        // live calendar and compare set
	int         num_errors = 0, checks = 0, seed = 99485, cyc = 0;
	int         lsb[7] = '{0, 6, 12, 17, 20, 25, 29}; // field base, seconds first
	always #50 aclk = ~aclk;
	rtcam_top dut_u (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cal_now(cal), .alarm_irq_q(irq)
	);
	// =====
	// compare and count
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// monitor takes the oldest note whenever an answer is taken
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (rvalid && rready) begin
			n = rq.pop_front();
			chk("read", {n.resp, n.data}, {rresp, rdata});
		end
		if (bvalid && bready) begin
			n = bq.pop_front();
			chk("write", {n.resp, 32'h0}, {bresp, 32'h0});
		end
		if (cyc == 6000) begin   // hang guard, a few times the run
			num_errors++;
			finish_test();
		end
	end
	// =====
	// bus master: offer, release what is taken, hold ready until the answer
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
		bq.push_back('{32'h0, r});
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
		rq.push_back('{v, r});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rready <= 1'h0;
	endtask
	// =====
	// setup words; armed status mirrors the arm bit
	function automatic logic [31:0] dword(logic [6:0] e, rtcam_cal_t c, logic a);
		return {2'h0, a, a, 1'h0, e[6:4], c.year, c.month, 3'h0, c.mday};
	endfunction
	function automatic logic [31:0] tword(logic [6:0] e, rtcam_cal_t c);
		return {e[3:0], 1'h0, c.weekday, 3'h0, c.hours, 2'h0, c.minutes, 2'h0, c.seconds};
	endfunction
	function automatic int rnd(int m);
		return $unsigned($random(seed)) % m;
	endfunction
	// values change only while disarmed, then arm and look at the raw flag
	task automatic arm_case(input logic [6:0] e, input rtcam_cal_t c, input logic hit);
		wr(8'h10, dlast, 2'h0);
		wr(8'h14, tword(e, c), 2'h0);
		dlast = dword(e, c, 1'h0);
		wr(8'h10, dlast, 2'h0);
		wr(8'h10, dword(e, c, 1'h1), 2'h0);
		repeat (8) @(posedge aclk);
		rd(8'h20, {31'h0, hit}, 2'h0);
		rd(8'h10, dword(e, c, 1'h1), 2'h0);
	endtask
	initial begin
		cal = {12'(rnd(4096)), 4'(rnd(12) + 1), 5'(rnd(31) + 1), 3'(rnd(7)),
			5'(rnd(24)), 6'(rnd(60)), 6'(rnd(60))};
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		// reset values of every writable and flag word
		foreach (lsb[i]) rd(8'h10 + 8'(4 * (i % 6 > 1 ? i + 2 : i)), 32'h0, 2'h0);
		rd(8'h1c, tword(7'h0, cal), 2'h0);
		rd(8'h18, dword(7'h0, cal, 1'h0), 2'h0);
		rd(8'h00, 32'h0, 2'h2);
		rd(8'h30, 32'h0, 2'h2);
		wr(8'h04, 32'hffff_ffff, 2'h2);
		wr(8'h20, 32'hffff_ffff, 2'h0);
		rd(8'h20, 32'h0, 2'h0);
		// random setup words read back through their storage masks
		d = $random(seed) & 32'hefff_ffff;
		wr(8'h10, d, 2'h0);
		rd(8'h10, d & 32'h07ff_ff1f, 2'h0);
		dlast = d;
		d = $random(seed);
		wr(8'h14, d, 2'h0);
		rd(8'h14, d & 32'hf71f_3f3f, 2'h0);
		// only the low byte lane written: seconds cleared, the rest kept
		@(posedge aclk);
		wstrb <= 4'h1;
		wr(8'h14, 32'h0, 2'h0);
		rd(8'h14, d & 32'hf71f_3f00, 2'h0);
		wstrb <= 4'hf;
		// each field alone breaks a match, all others still make it
		for (int f = 0; f < 7; f++) begin
			cmp = cal ^ (one << lsb[f]);
			arm_case(7'h01 << f, cmp, 1'h0);
			arm_case(~(7'h01 << f), cmp, 1'h1);
		end
		// seconds alone at 54 keeps matching while minutes move
		@(posedge aclk);
		cal.seconds <= 6'h36;
		cmp = cal;
		cmp.seconds = 6'h36;
		arm_case(7'h01, cmp, 1'h1);
		@(posedge aclk);
		cal.minutes <= 6'(rnd(60));
		repeat (8) @(posedge aclk);
		rd(8'h20, 32'h1, 2'h0);
		chk("irq pin", 34'h0, {33'h0, irq});
		rd(8'h2c, 32'h0, 2'h0);
		wr(8'h24, 32'hffff_ffff, 2'h0);
		repeat (3) @(posedge aclk);
		chk("irq pin", 34'h1, {33'h0, irq});
		rd(8'h24, 32'h1, 2'h0);
		rd(8'h2c, 32'h1, 2'h0);
		@(posedge aclk);
		cal.seconds <= 6'h37;
		repeat (8) @(posedge aclk);
		rd(8'h20, 32'h0, 2'h0);
		chk("irq pin", 34'h0, {33'h0, irq});
		wr(8'h28, 32'h1, 2'h0);
		repeat (3) @(posedge aclk);
		chk("irq pin", 34'h1, {33'h0, irq});
		rd(8'h28, 32'h1, 2'h0);
		rd(8'h2c, 32'h1, 2'h0);
		wr(8'h28, 32'h0, 2'h0);
		wr(8'h24, 32'h0, 2'h0);
		repeat (3) @(posedge aclk);
		chk("irq pin", 34'h0, {33'h0, irq});
		finish_test();
	end
endmodule
